/* File: verilog/slea_pkg.sv */
// Purpose: shared constants and types for the second level event aggregator
// Assumes: 32-bit register port, one word per register
// Notes: offsets are byte addresses on the plain register port
package slea_pkg;
	localparam int ADDR_W = 8;
	localparam int TOP_W = 17;
	// top-level request positions
	localparam int TOP_TMR1 = 0;
	localparam int TOP_TMR2 = 1;
	localparam int TOP_SC1 = 5;
	localparam int TOP_SC2 = 6;
	localparam int TOP_ADC = 11;
	// second-level widths and implemented bits
	localparam int TMR_W = 7;
	localparam int SC1_W = 15;
	localparam int SC2_W = 13;
	localparam int ADC_W = 5;
	localparam int NMI_W = 2;
	localparam logic [TMR_W-1:0] TMR_VALID = 7'h5F;
	localparam int NMI_XTAL = 0;
	localparam int NMI_WDOG = 1;
	// register offsets
	localparam logic [ADDR_W-1:0] OFF_TMR1_FLAG = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_TMR2_FLAG = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SC1_FLAG = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_SC2_FLAG = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_ADC_FLAG = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_NMI_FLAG = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_TMR1_CFG = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_TMR2_CFG = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_SC1_CFG = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_SC2_CFG = 8'h2C;
	localparam logic [ADDR_W-1:0] OFF_ADC_CFG = 8'h30;
	localparam logic [ADDR_W-1:0] OFF_NMI_CFG = 8'h34;
	localparam logic [ADDR_W-1:0] OFF_MISS = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_AFSR = 8'h44;
	localparam logic [ADDR_W-1:0] OFF_WDOG_CTRL = 8'h48;
	localparam logic [ADDR_W-1:0] OFF_WDOG_KICK = 8'h4C;
	localparam logic [ADDR_W-1:0] OFF_CLK_STAT = 8'h50;
	// aux fault status fields
	localparam int AFSR_W = 4;
	localparam int AFSR_BAD_WIDTH_FAULT = 0;
	localparam int AFSR_PROTECT = 1;
	localparam int AFSR_RESERVED = 2;
	localparam int AFSR_MISSED = 3;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	// watchdog low-water time
	localparam longint WDOG_LOW_MS = 1792;
	localparam longint CLK_KHZ = 125000;
	localparam int unsigned WDOG_LOW_CYCLES = 32'(WDOG_LOW_MS * CLK_KHZ);

	typedef struct packed {
		logic valid;
		logic write;
		logic priv;
		logic [1:0] size;
		logic [1:0] addr_lo;
		logic apb;
		logic sys_periph;
		logic prot_ram;
		logic above_last;
		logic above_mem;
	} slea_access_s;
endpackage

/* File: verilog/slea_flag_bank.sv */
// Purpose: one peripheral's enable mask, sticky flags and miss detect
// Assumes: events are one-cycle pulses on ref_clk_i
// Notes: req_o and miss_o are combinational, registered by the parent
`timescale 1ns/1ps
`default_nettype none
module slea_flag_bank #(
	parameter int W = 8,
	parameter logic [W-1:0] VALID = '1
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] event_i,
	input wire logic cfg_we_i,
	input wire logic flag_we_i,
	input wire logic [W-1:0] wdata_i,
	output logic [W-1:0] cfg_o,
	output logic [W-1:0] flag_o,
	output logic req_o,
	output logic miss_o
);
	logic [W-1:0] cfg_r;
	logic [W-1:0] flag_r;
	logic [W-1:0] clr;
	logic [W-1:0] flag_nxt;

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
			cfg_r <= '0;
		else if (cfg_we_i)
			cfg_r <= wdata_i & VALID;
	end

	// event is or-ed in last, so a same-cycle clear loses
	assign clr = flag_we_i ? wdata_i : '0;
	assign flag_nxt = ((flag_r & ~clr) | event_i) & VALID;

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
			flag_r <= '0;
		else
			flag_r <= flag_nxt;
	end

	assign req_o = |(flag_r & cfg_r);
	assign miss_o = |(event_i & flag_r & cfg_r & VALID);
	assign cfg_o = cfg_r;
	assign flag_o = flag_r;
endmodule
`default_nettype wire

/* File: verilog/slea_top.sv */
// Purpose: second level event aggregator with nmi sources and bus fault status
// Assumes: peripheral events and bus access info are on ref_clk_i
// Notes: requests reach the outputs one cycle after the flag state
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module slea_top
	import slea_pkg::*;
#(
	parameter int unsigned WDOG_CYCLES = WDOG_LOW_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [TMR_W-1:0] tmr1_ev_i,
	input wire logic [TMR_W-1:0] tmr2_ev_i,
	input wire logic [SC1_W-1:0] sc1_ev_i,
	input wire logic [SC2_W-1:0] sc2_ev_i,
	input wire logic [ADC_W-1:0] adc_ev_i,
	input wire logic [TOP_W-1:0] direct_irq_i,
	input wire logic xtal_sel_i,
	input wire logic xtal_fail_i,
	input wire slea_access_s access_i,
	output logic [TOP_W-1:0] irq_o,
	output logic nmi_o,
	output logic clk_on_rc_o,
	output logic bus_fault_o,
	output logic hard_fault_o
);
	logic [TMR_W-1:0] t1_cfg, t1_flag, t2_cfg, t2_flag;
	logic [SC1_W-1:0] s1_cfg, s1_flag;
	logic [SC2_W-1:0] s2_cfg, s2_flag;
	logic [ADC_W-1:0] ad_cfg, ad_flag;
	logic [NMI_W-1:0] nm_cfg, nm_flag, nmi_ev;
	logic t1_req, t2_req, s1_req, s2_req, ad_req, nm_req;
	logic t1_miss, t2_miss, s1_miss, s2_miss, ad_miss;
	logic [TOP_W-1:0] miss_r, miss_set, req_map;
	logic [AFSR_W-1:0] afsr_r, fault;
	logic xf_meta_r, xf_sync_r, clk_on_rc_r, clk_on_rc_d_r;
	logic wdog_en_r, wdog_hit_r;
	logic [31:0] wdog_cnt_r;
	logic [31:0] rdata_nxt;
	logic any_fault, prior_fault;

	function automatic logic wr_at(input logic [ADDR_W-1:0] off);
		return wr_i && (addr_i == off);
	endfunction

	// flag banks, one per peripheral
	slea_flag_bank #(.W(TMR_W), .VALID(TMR_VALID)) u_tmr1 (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .event_i(tmr1_ev_i),
		.cfg_we_i(wr_at(OFF_TMR1_CFG)), .flag_we_i(wr_at(OFF_TMR1_FLAG)),
		.wdata_i(wdata_i[TMR_W-1:0]), .cfg_o(t1_cfg), .flag_o(t1_flag),
		.req_o(t1_req), .miss_o(t1_miss));
	slea_flag_bank #(.W(TMR_W), .VALID(TMR_VALID)) u_tmr2 (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .event_i(tmr2_ev_i),
		.cfg_we_i(wr_at(OFF_TMR2_CFG)), .flag_we_i(wr_at(OFF_TMR2_FLAG)),
		.wdata_i(wdata_i[TMR_W-1:0]), .cfg_o(t2_cfg), .flag_o(t2_flag),
		.req_o(t2_req), .miss_o(t2_miss));
	slea_flag_bank #(.W(SC1_W)) u_sc1 (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .event_i(sc1_ev_i),
		.cfg_we_i(wr_at(OFF_SC1_CFG)), .flag_we_i(wr_at(OFF_SC1_FLAG)),
		.wdata_i(wdata_i[SC1_W-1:0]), .cfg_o(s1_cfg), .flag_o(s1_flag),
		.req_o(s1_req), .miss_o(s1_miss));
	slea_flag_bank #(.W(SC2_W)) u_sc2 (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .event_i(sc2_ev_i),
		.cfg_we_i(wr_at(OFF_SC2_CFG)), .flag_we_i(wr_at(OFF_SC2_FLAG)),
		.wdata_i(wdata_i[SC2_W-1:0]), .cfg_o(s2_cfg), .flag_o(s2_flag),
		.req_o(s2_req), .miss_o(s2_miss));
	slea_flag_bank #(.W(ADC_W)) u_adc (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .event_i(adc_ev_i),
		.cfg_we_i(wr_at(OFF_ADC_CFG)), .flag_we_i(wr_at(OFF_ADC_FLAG)),
		.wdata_i(wdata_i[ADC_W-1:0]), .cfg_o(ad_cfg), .flag_o(ad_flag),
		.req_o(ad_req), .miss_o(ad_miss));
	slea_flag_bank #(.W(NMI_W)) u_nmi (
		.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .event_i(nmi_ev),
		.cfg_we_i(wr_at(OFF_NMI_CFG)), .flag_we_i(wr_at(OFF_NMI_FLAG)),
		.wdata_i(wdata_i[NMI_W-1:0]), .cfg_o(nm_cfg), .flag_o(nm_flag),
		.req_o(nm_req), .miss_o());

	// aggregated peripherals override the direct lines at their positions
	always_comb
	begin
		req_map = direct_irq_i;
		req_map[TOP_TMR1] = t1_req;
		req_map[TOP_TMR2] = t2_req;
		req_map[TOP_SC1] = s1_req;
		req_map[TOP_SC2] = s2_req;
		req_map[TOP_ADC] = ad_req;
		miss_set = '0;
		miss_set[TOP_TMR1] = t1_miss;
		miss_set[TOP_TMR2] = t2_miss;
		miss_set[TOP_SC1] = s1_miss;
		miss_set[TOP_SC2] = s2_miss;
		miss_set[TOP_ADC] = ad_miss;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			irq_o <= '0;
			nmi_o <= 1'b0;
		end
		else
		begin
			irq_o <= req_map;
			nmi_o <= nm_req;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
			miss_r <= '0;
		else if (wr_at(OFF_MISS))
			miss_r <= (miss_r & ~wdata_i[TOP_W-1:0]) | miss_set;
		else
			miss_r <= miss_r | miss_set;
	end

	// crystal failure pin comes from the oscillator, not this clock
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			xf_meta_r <= 1'b0;
			xf_sync_r <= 1'b0;
		end
		else
		begin
			xf_meta_r <= xtal_fail_i;
			xf_sync_r <= xf_meta_r;
		end
	end

	// switch is sticky until reset; software cannot fall back to a dead crystal
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			clk_on_rc_r <= 1'b0;
			clk_on_rc_d_r <= 1'b0;
		end
		else
		begin
			if (xtal_sel_i && xf_sync_r)
				clk_on_rc_r <= 1'b1;
			clk_on_rc_d_r <= clk_on_rc_r;
		end
	end
	assign clk_on_rc_o = clk_on_rc_r;

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
			wdog_en_r <= 1'b0;
		else if (wr_at(OFF_WDOG_CTRL))
			wdog_en_r <= wdata_i[0];
	end

	// counter parks at the hit so the event fires once per starvation
	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			wdog_cnt_r <= '0;
			wdog_hit_r <= 1'b0;
		end
		else if (!wdog_en_r || wr_at(OFF_WDOG_KICK))
		begin
			wdog_cnt_r <= '0;
			wdog_hit_r <= 1'b0;
		end
		else if (wdog_cnt_r != WDOG_CYCLES - 1)
		begin
			wdog_cnt_r <= wdog_cnt_r + 32'h1;
			// hit rises as the count lands on its last value
			// and drops while parked, so one pulse per starvation
			wdog_hit_r <= (wdog_cnt_r == WDOG_CYCLES - 2);
		end
		else
			wdog_hit_r <= 1'b0;
	end

	// event in the first cycle that the switch shows on clk_on_rc_r
	always_comb
	begin
		nmi_ev = '0;
		nmi_ev[NMI_XTAL] = clk_on_rc_r && !clk_on_rc_d_r;
		nmi_ev[NMI_WDOG] = wdog_hit_r;
	end

	// causes are computed independently so several can fire together
	always_comb
	begin
		fault = '0;
		if (access_i.valid)
		begin
			fault[AFSR_BAD_WIDTH_FAULT] = access_i.apb &&
				(access_i.size != SIZE_WORD || access_i.addr_lo != 2'h0);
			fault[AFSR_PROTECT] = access_i.write && !access_i.priv &&
				(access_i.sys_periph || access_i.prot_ram);
			fault[AFSR_RESERVED] = access_i.above_last || access_i.above_mem;
		end
	end
	assign any_fault = |fault;
	assign prior_fault = |afsr_r[AFSR_RESERVED:AFSR_BAD_WIDTH_FAULT];

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
			afsr_r <= '0;
		else
		begin
			afsr_r <= (wr_at(OFF_AFSR) ? afsr_r & ~wdata_i[AFSR_W-1:0] : afsr_r) | fault;
			if (any_fault && prior_fault)
				afsr_r[AFSR_MISSED] <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
		begin
			bus_fault_o <= 1'b0;
			hard_fault_o <= 1'b0;
		end
		else
		begin
			bus_fault_o <= any_fault && !prior_fault;
			hard_fault_o <= any_fault && prior_fault;
		end
	end

	always_comb
	begin
		rdata_nxt = 32'h0;
		case (addr_i)
			OFF_TMR1_FLAG: rdata_nxt[TMR_W-1:0] = t1_flag;
			OFF_TMR2_FLAG: rdata_nxt[TMR_W-1:0] = t2_flag;
			OFF_SC1_FLAG: rdata_nxt[SC1_W-1:0] = s1_flag;
			OFF_SC2_FLAG: rdata_nxt[SC2_W-1:0] = s2_flag;
			OFF_ADC_FLAG: rdata_nxt[ADC_W-1:0] = ad_flag;
			OFF_NMI_FLAG: rdata_nxt[NMI_W-1:0] = nm_flag;
			OFF_TMR1_CFG: rdata_nxt[TMR_W-1:0] = t1_cfg;
			OFF_TMR2_CFG: rdata_nxt[TMR_W-1:0] = t2_cfg;
			OFF_SC1_CFG: rdata_nxt[SC1_W-1:0] = s1_cfg;
			OFF_SC2_CFG: rdata_nxt[SC2_W-1:0] = s2_cfg;
			OFF_ADC_CFG: rdata_nxt[ADC_W-1:0] = ad_cfg;
			OFF_NMI_CFG: rdata_nxt[NMI_W-1:0] = nm_cfg;
			OFF_MISS: rdata_nxt[TOP_W-1:0] = miss_r;
			OFF_AFSR: rdata_nxt[AFSR_W-1:0] = afsr_r;
			OFF_WDOG_CTRL: rdata_nxt[0] = wdog_en_r;
			OFF_CLK_STAT: rdata_nxt[0] = clk_on_rc_r;
			default: rdata_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!resetn_i)
			rdata_o <= 32'h0;
		else if (rd_i)
			rdata_o <= rdata_nxt;
		else
			rdata_o <= 32'h0;
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_enable_pending;
		wr_at(OFF_TMR1_CFG) && wdata_i[0] && t1_flag[0] && !wr_at(OFF_TMR1_FLAG);
	endsequence
	sequence s_xtal_switch;
		xtal_sel_i && xf_sync_r && !clk_on_rc_r ##1 clk_on_rc_r;
	endsequence

	a_req_or: assert property (irq_o[TOP_TMR1] == $past(|(t1_flag & t1_cfg)))
		else $error("timer 1 request is not the or of enabled flags");
	a_mask_blocks: assert property (t1_cfg == '0 |=> !irq_o[TOP_TMR1])
		else $error("masked flags reached the request");
	a_w1c_clear: assert property (wr_at(OFF_SC1_FLAG) && wdata_i[3] && !sc1_ev_i[3]
		|=> !s1_flag[3])
		else $error("write one did not clear the flag");
	a_zero_keeps: assert property (wr_at(OFF_SC1_FLAG) && !wdata_i[3] && s1_flag[3]
		|=> s1_flag[3])
		else $error("write zero changed a flag");
	a_set_wins: assert property (adc_ev_i[0] && wr_at(OFF_ADC_FLAG) && wdata_i[0]
		|=> ad_flag[0])
		else $error("event lost against a clear");
	a_pend_enable: assert property (s_enable_pending |-> ##2 irq_o[TOP_TMR1])
		else $error("pending flag not propagated on enable");
	a_hold_req: assert property (|(s2_flag & s2_cfg) |=> irq_o[TOP_SC2])
		else $error("request dropped with an enabled flag set");
	a_miss_set: assert property (tmr2_ev_i[0] && t2_flag[0] && t2_cfg[0]
		|=> miss_r[TOP_TMR2])
		else $error("lost event not recorded");
	a_miss_clear: assert property (wr_at(OFF_MISS) && wdata_i[TOP_ADC] && !ad_miss
		|=> !miss_r[TOP_ADC])
		else $error("miss bit did not clear");
	a_xtal_nmi: assert property (s_xtal_switch ##0 nm_cfg[NMI_XTAL] ##0 !wr_at(OFF_NMI_FLAG)
		|-> ##1 nm_flag[NMI_XTAL] ##1 nmi_o)
		else $error("crystal failure did not raise nmi");
	a_bad_width: assert property (access_i.valid && access_i.apb && access_i.size != SIZE_WORD
		|=> afsr_r[AFSR_BAD_WIDTH_FAULT])
		else $error("bad width fault not recorded");
	a_second_fault: assert property (any_fault && prior_fault
		|=> afsr_r[AFSR_MISSED] && hard_fault_o)
		else $error("second fault not flagged");
endmodule
`default_nettype wire

/* File: bench/slea_periph_model.sv */
// Purpose: peripheral side of the aggregator, turns fire requests into event pulses
// Assumes: fire_i is held for exactly one ref_clk_i cycle by the bench
// Notes: pulses only, a held level would look like repeated events
`timescale 1ns/1ps
`default_nettype none
module slea_periph_model
	import slea_pkg::*;
(
	input wire logic fire_i,
	input wire logic [2:0] bank_i,
	input wire logic [14:0] mask_i,
	output logic [TMR_W-1:0] tmr1_o,
	output logic [TMR_W-1:0] tmr2_o,
	output logic [SC1_W-1:0] sc1_o,
	output logic [SC2_W-1:0] sc2_o,
	output logic [ADC_W-1:0] adc_o
);
	// unimplemented bits are sent too, the block must drop them
	assign tmr1_o = (fire_i && bank_i == 3'h0) ? mask_i[TMR_W-1:0] : '0;
	assign tmr2_o = (fire_i && bank_i == 3'h1) ? mask_i[TMR_W-1:0] : '0;
	assign sc1_o = (fire_i && bank_i == 3'h2) ? mask_i[SC1_W-1:0] : '0;
	assign sc2_o = (fire_i && bank_i == 3'h3) ? mask_i[SC2_W-1:0] : '0;
	assign adc_o = (fire_i && bank_i == 3'h4) ? mask_i[ADC_W-1:0] : '0;
endmodule
`default_nettype wire

/* File: bench/slea_top_tb.sv */
// Purpose: self-checking bench for the event aggregator
// Assumes: watchdog span shortened to 20 cycles
// Notes: requests follow flags by one cycle and writes by two cycles
`timescale 1ns/1ps
`default_nettype none
module slea_top_tb
	import slea_pkg::*;
;
	localparam logic [7:0] FO [5] = '{OFF_TMR1_FLAG, OFF_TMR2_FLAG, OFF_SC1_FLAG,
		OFF_SC2_FLAG, OFF_ADC_FLAG};
	localparam logic [7:0] CO [5] = '{OFF_TMR1_CFG, OFF_TMR2_CFG, OFF_SC1_CFG,
		OFF_SC2_CFG, OFF_ADC_CFG};
	localparam int TP [5] = '{TOP_TMR1, TOP_TMR2, TOP_SC1, TOP_SC2, TOP_ADC};
	localparam logic [14:0] VM [5] = '{15'(TMR_VALID), 15'(TMR_VALID), 15'h7FFF,
		15'h1FFF, 15'h001F};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fire = 1'b0;
	logic xsel = 1'b0;
	logic xfail = 1'b0;
	logic [7:0] addr = '0;
	logic [31:0] wd = '0;
	logic [2:0] bank = '0;
	logic [14:0] mask = '0;
	logic [16:0] dir = '0;
	slea_access_s acc = '0;
	logic [31:0] rdat;
	logic [16:0] irq;
	logic nmi, onrc, bf, hf;
	logic [TMR_W-1:0] t1, t2;
	logic [SC1_W-1:0] s1;
	logic [SC2_W-1:0] s2;
	logic [ADC_W-1:0] ad;
	logic [31:0] lf = 32'h00012038;
	logic [14:0] m, e;
	int errors = 0;
	int check_count = 0;

	slea_periph_model u_model (.fire_i(fire), .bank_i(bank), .mask_i(mask), .tmr1_o(t1),
		.tmr2_o(t2), .sc1_o(s1), .sc2_o(s2), .adc_o(ad));
	slea_top #(.WDOG_CYCLES(20)) DUT (.ref_clk_i(clk), .resetn_i(rstn), .addr_i(addr),
		.wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .tmr1_ev_i(t1), .tmr2_ev_i(t2),
		.sc1_ev_i(s1), .sc2_ev_i(s2), .adc_ev_i(ad), .direct_irq_i(dir), .xtal_sel_i(xsel),
		.xtal_fail_i(xfail), .access_i(acc), .irq_o(irq), .nmi_o(nmi), .clk_on_rc_o(onrc),
		.bus_fault_o(bf), .hard_fault_o(hf));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// fl holds apb, sys_periph, prot_ram, above_last, above_mem
	function automatic slea_access_s acc_f(input logic w, pv, input logic [1:0] sz, lo,
		input logic [4:0] fl);
		return '{1'b1, w, pv, sz, lo, fl[4], fl[3], fl[2], fl[1], fl[0]};
	endfunction
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdat, x);
	endtask
	// clr also writes one to flag bit0 in the very cycle of the event, and the event wins
	task automatic fire_ev(input int b, input logic [14:0] mk, input logic clr);
		@(posedge clk);
		fire <= 1'b1;
		bank <= b[2:0];
		mask <= mk;
		wr <= clr;
		addr <= FO[b];
		wd <= 32'h00000001;
		@(posedge clk);
		fire <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic flt(input slea_access_s a, input logic [1:0] x);
		@(posedge clk);
		acc <= a;
		@(posedge clk);
		acc <= '0;
		#1;
		chk({30'h0, bf, hf}, {30'h0, x});
	endtask

	initial
	begin
		forever #4 clk = ~clk;
	end
	initial
	begin
		#200000;
		errors++;
		stop_test;
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		for (int b = 0; b < 5; b++)
		begin
			rdc(FO[b], 32'h0);
			rdc(CO[b], 32'h0);
		end
		rdc(OFF_MISS, 32'h0);
		wrr(8'h3C, 32'hFFFFFFFF);
		rdc(8'h3C, 32'h0);
		lf = lfsr_next(lf);
		@(posedge clk);
		dir <= lf[16:0];
		cyc(3);
		chk({15'h0, irq & 17'h1F79C}, {15'h0, lf[16:0] & 17'h1F79C});
		for (int b = 0; b < 5; b++)
		begin
			lf = lfsr_next(lf);
			m = lf[14:0] | 15'h0003;
			e = m & VM[b];
			fire_ev(b, m, 1'b0);
			rdc(FO[b], {17'h0, e});
			cyc(2);
			chk({31'h0, irq[TP[b]]}, 32'h0);
			wrr(CO[b], {17'h0, VM[b]});
			cyc(2);
			chk({31'h0, irq[TP[b]]}, 32'h1);
			fire_ev(b, 15'h0001, 1'b1);
			rdc(FO[b], {17'h0, e});
			rdc(OFF_MISS, 32'h1 << TP[b]);
			wrr(OFF_MISS, 32'h0);
			rdc(OFF_MISS, 32'h1 << TP[b]);
			wrr(OFF_MISS, 32'h1 << TP[b]);
			rdc(OFF_MISS, 32'h0);
			wrr(FO[b], 32'h1);
			cyc(2);
			chk({31'h0, irq[TP[b]]}, 32'h1);
			rdc(FO[b], {17'h0, e & 15'h7FFE});
			wrr(FO[b], 32'hFFFFFFFF);
			cyc(2);
			chk({31'h0, irq[TP[b]]}, 32'h0);
			wrr(CO[b], 32'h0);
		end
		wrr(OFF_NMI_CFG, 32'h3);
		@(posedge clk);
		xsel <= 1'b1;
		xfail <= 1'b1;
		cyc(8);
		chk({30'h0, onrc, nmi}, 32'h3);
		rdc(OFF_CLK_STAT, 32'h1);
		@(posedge clk);
		xfail <= 1'b0;
		xsel <= 1'b0;
		wrr(OFF_NMI_FLAG, 32'h1);
		cyc(2);
		chk({31'h0, nmi}, 32'h0);
		wrr(OFF_WDOG_CTRL, 32'h1);
		cyc(12);
		wrr(OFF_WDOG_KICK, 32'h0);
		cyc(12);
		rdc(OFF_NMI_FLAG, 32'h0);
		cyc(10);
		rdc(OFF_NMI_FLAG, 32'h2);
		chk({31'h0, nmi}, 32'h1);
		wrr(OFF_WDOG_CTRL, 32'h0);
		wrr(OFF_NMI_FLAG, 32'h3);
		flt(acc_f(1'b0, 1'b1, 2'h0, 2'h0, 5'h10), 2'h2);
		rdc(OFF_AFSR, 32'h1);
		flt(acc_f(1'b1, 1'b0, SIZE_WORD, 2'h0, 5'h08), 2'h1);
		rdc(OFF_AFSR, 32'hB);
		wrr(OFF_AFSR, 32'hF);
		flt(acc_f(1'b1, 1'b1, SIZE_WORD, 2'h0, 5'h18), 2'h0);
		flt(acc_f(1'b1, 1'b0, SIZE_WORD, 2'h2, 5'h1A), 2'h2);
		rdc(OFF_AFSR, 32'h7);
		wrr(OFF_AFSR, 32'h7);
		flt(acc_f(1'b0, 1'b1, SIZE_WORD, 2'h0, 5'h01), 2'h2);
		rdc(OFF_AFSR, 32'h4);
		stop_test;
	end
endmodule
`default_nettype wire
